// file: rtl/ticl_pkg.sv
package ticl_pkg;

    // ==========================================================
    // Timing figures, in nanoseconds
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS     = 25;
    localparam int unsigned STROBE_NEAR_NS    = 8000;   // Short copy of run normal
    localparam int unsigned STROBE_FAR_NS     = 16000;  // Long copy of run normal
    localparam int unsigned REWIND_PULSE_NS   = 5000;
    localparam int unsigned QUAL_DELAY_NS     = 4000;   // Least of the 4 to 6 us window
    localparam int unsigned SAMPLE_OSC_NS     = 1000;   // Sampling oscillator period

    // Cycle counts derived from the figures above
    localparam int unsigned STROBE_NEAR_CYC  = (STROBE_NEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_FAR_CYC   = (STROBE_FAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REWIND_PULSE_CYC = REWIND_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned QUAL_DELAY_CYC   = (QUAL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_OSC_CYC   = SAMPLE_OSC_NS / CLK_PERIOD_NS;

    // Counter width shared by the delay module and the core counters
    localparam int unsigned CNT_W = 10;

    // Controller motion request
    typedef struct packed {
        logic fwd;
        logic rev;
        logic fast;
    } ticl_motion_s;

    // Internal motion outputs
    typedef struct packed {
        logic run_normal;
        logic run_fast;
        logic reverse_out;
    } ticl_drive_s;

    // Write requests from the controller
    typedef struct packed {
        logic set_write_status;
        logic overwrite_req;
    } ticl_wreq_s;

endpackage : ticl_pkg

// file: rtl/ticl_delay.sv
`timescale 1ns/100ps

// ==========================================================
// Rising-edge delay: output follows input high only after
// the input has stayed high for DELAY cycles; falls at once
// ==========================================================
module ticl_delay #(
    parameter int unsigned DELAY = 1
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);

    logic [ticl_pkg::CNT_W-1:0] count_r;

    initial begin
        if (DELAY < 1 || DELAY >= (1 << ticl_pkg::CNT_W)) begin
            $error("ticl_delay: DELAY out of range");
        end
    end

    // Count while high, clear at once when low (RC charge / dump)
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_r <= '0;
        end else if (!din) begin
            count_r <= '0;
        end else if (count_r != ticl_pkg::CNT_W'(DELAY)) begin
            count_r <= count_r + ticl_pkg::CNT_W'(1);
        end
    end

    assign dout = din && (count_r == ticl_pkg::CNT_W'(DELAY));

endmodule : ticl_delay

// file: rtl/ticl_core.sv
`timescale 1ns/100ps

// How it works
// - Forward, reverse and fast requests map onto normal, fast and reverse outputs.
// - Direction latches only on sampling ticks, which run only while tape is stopped.
// - Reverse request is ignored while the tape sits at load point.
// - Fast forward in the same direction needs no stop first.
// - End of tape drops run fast when running forward, leaving normal-speed running.
// - Busy or not selected forces every motion output off.
// - Two delayed copies of run normal form an 8 us strobe sampling writes.
// - Write select follows sampled write status while erase bar disable is off.
// - Write select only changes at the motion-start sampling point or when overwrite ends.
// - Sampled overwrite sets overwrite flop, holds write select, disables erase bar.
// - Write-after-read strobe clears overwrite flop, dropping write select.
// - Rewind command away from load point sets rewind status and rewinding output.
// - Accepting rewind emits one 5 us rewind pulse.
// - Rewinding hold keeps rewind status set.
// - Rewind status clears at stopped load point or on broken tape.
// - Ready is true when not rewinding, selected, on line and not busy.
// - Unload command, strap gated, sets unload flop; unload out when not rewinding.
// - Broken tape clears both unload and rewind status flops.
// - Unload away from load point also starts rewind and takes unit off line.
// - Selected and on-line qualifiers gating rewind and unload are delayed 4 to 6 us.
// - Tape moving is high while in motion, low once stopped.
// - Busy means rewinding or searching load point; no motion then.
module ticl_core (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire ticl_pkg::ticl_motion_s motion_req,
    input  wire ticl_pkg::ticl_wreq_s  write_req,
    input  wire logic                  write_after_read_strobe,
    input  wire logic                  tape_moving,
    input  wire logic                  at_load_point,
    input  wire logic                  end_of_tape,
    input  wire logic                  busy_in,
    input  wire logic                  unit_selected,
    input  wire logic                  in_service,
    input  wire logic                  rewind_cmd,
    input  wire logic                  rewinding_hold,
    input  wire logic                  broken_tape,
    input  wire logic                  unload_cmd,
    input  wire logic                  unload_gating_strap,
    output ticl_pkg::ticl_drive_s      drive,
    output logic                       write_select,
    output logic                       erase_bar_disable,
    output logic                       rewinding_status,
    output logic                       rewind_pulse,
    output logic                       ready,
    output logic                       unload_out,
    output logic                       go_offline_cmd
);
    // Every check below runs on the one clock and sleeps in reset
    default clocking cb_core @(posedge clock); endclocking
    default disable iff (reset);

    // ==========================================================
    // Input synchronisers (all inputs come from pins)
    // ==========================================================
    localparam int unsigned NSYNC = 17;

    logic [NSYNC-1:0] pin_meta_r;
    logic [NSYNC-1:0] pin_sync_r;
    logic [NSYNC-1:0] pin_raw;

    assign pin_raw = {motion_req.fwd, motion_req.rev, motion_req.fast,
                      write_req.set_write_status, write_req.overwrite_req,
                      write_after_read_strobe, tape_moving, at_load_point,
                      end_of_tape, busy_in, unit_selected, in_service,
                      rewind_cmd, rewinding_hold, broken_tape, unload_cmd, unload_gating_strap};

    // Two stages; only the second stage feeds logic
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    logic s_fwd, s_rev, s_fast, s_sws, s_ovw, s_wars, s_moving, s_lp;
    logic s_eot, s_busy, s_sel, s_onl, s_rwc, s_hold, s_bkn, s_unload_cmd, s_strap;
    // Strap is static but still a pin, so it rides the same two stages
    assign {s_fwd, s_rev, s_fast, s_sws, s_ovw, s_wars, s_moving, s_lp,
            s_eot, s_busy, s_sel, s_onl, s_rwc, s_hold, s_bkn, s_unload_cmd, s_strap} = pin_sync_r;

    // ==========================================================
    // Qualifier delay
    // ==========================================================
    logic sel_onl_dly;

    ticl_delay #(.DELAY (ticl_pkg::QUAL_DELAY_CYC)) u_qual_delay (
        .clock (clock),
        .reset (reset),
        .din   (s_sel && s_onl),
        .dout  (sel_onl_dly)
    );

    // ==========================================================
    // Sampling oscillator and direction interlock
    // ==========================================================
    logic [ticl_pkg::CNT_W-1:0] osc_cnt_r;
    logic                       osc_tick;
    logic                       dir_fwd_r;

    // oscillator gated by motion; moving stops it; counter
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            osc_cnt_r <= '0;
        end else if (s_moving || osc_cnt_r == ticl_pkg::CNT_W'(ticl_pkg::SAMPLE_OSC_CYC - 1)) begin
            osc_cnt_r <= '0;
        end else begin
            osc_cnt_r <= osc_cnt_r + ticl_pkg::CNT_W'(1);
        end
    end

    assign osc_tick = !s_moving && (osc_cnt_r == ticl_pkg::CNT_W'(ticl_pkg::SAMPLE_OSC_CYC - 1));

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dir_fwd_r <= 1'b1;
        end else if (osc_tick) begin
            dir_fwd_r <= s_fwd;
        end
    end

    // ==========================================================
    // Motion output mapping
    // ==========================================================
    logic motion_enable;
    logic rev_req_ok;
    logic run_normal_c;
    logic run_fast_c;
    logic reverse_c;

    // busy or deselect blocks; busy means no motion
    assign motion_enable = !s_busy && s_sel;
    assign rev_req_ok    = s_rev && !s_lp;

    // command mapping; same-direction fast; end of tape
    always_comb begin
        run_normal_c = 1'b0;
        run_fast_c   = 1'b0;
        reverse_c    = 1'b0;
        if (motion_enable) begin
            if (dir_fwd_r && s_fwd) begin
                run_normal_c = 1'b1;
                run_fast_c   = s_fast && !s_eot;
            end else if (!dir_fwd_r && rev_req_ok) begin
                run_normal_c = 1'b1;
                run_fast_c   = s_fast;
                reverse_c    = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            drive <= '0;
        end else begin
            drive <= {run_normal_c, run_fast_c, reverse_c};
        end
    end

    // ==========================================================
    // Write sampling strobe
    // ==========================================================
    logic rn_near;
    logic rn_far;
    logic sample_strobe;
    logic sample_strobe_d_r;
    logic sample_edge;

    ticl_delay #(.DELAY (ticl_pkg::STROBE_NEAR_CYC)) u_rn_near (
        .clock (clock),
        .reset (reset),
        .din   (drive.run_normal),
        .dout  (rn_near)
    );

    ticl_delay #(.DELAY (ticl_pkg::STROBE_FAR_CYC)) u_rn_far (
        .clock (clock),
        .reset (reset),
        .din   (drive.run_normal),
        .dout  (rn_far)
    );

    // strobe high from 8 us to 16 us after run normal rises
    assign sample_strobe = rn_near && !rn_far;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sample_strobe_d_r <= 1'b0;
        end else begin
            sample_strobe_d_r <= sample_strobe;
        end
    end

    // Sample on the trailing edge, about 16 us in, within 15 to 20 us
    assign sample_edge = sample_strobe_d_r && !sample_strobe;

    // ==========================================================
    // Write select and overwrite
    // ==========================================================
    logic sws_r;
    logic ovw_ff_r;

    // changes only at sample; overwrite end drops it; valid requests
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sws_r <= 1'b0;
        end else if (sample_edge) begin
            sws_r <= s_sws;
        end else if (s_wars && ovw_ff_r) begin
            sws_r <= 1'b0;
        end
    end

    // overwrite set at sample; strobe clears it; set wins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ovw_ff_r <= 1'b0;
        end else if (sample_edge && s_ovw) begin
            ovw_ff_r <= 1'b1;
        end else if (s_wars) begin
            ovw_ff_r <= 1'b0;
        end
    end

    // normal write; overwrite holds select; needs both requests
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            write_select      <= 1'b0;
            erase_bar_disable <= 1'b0;
        end else begin
            write_select      <= sws_r;
            erase_bar_disable <= ovw_ff_r;
        end
    end

    // ==========================================================
    // Rewind status
    // ==========================================================
    logic rwc_d_r;
    logic rwc_accept;
    logic unload_cmd_rewind;
    logic rewind_ff_r;
    logic stopped_at_lp;
    logic [ticl_pkg::CNT_W-1:0] rw_pulse_cnt_r;

    // unload away from load point also rewinds
    assign unload_cmd_rewind = s_unload_cmd && !s_lp;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rwc_d_r <= 1'b0;
        end else begin
            rwc_d_r <= (s_rwc && sel_onl_dly) || unload_cmd_rewind;
        end
    end

    // accept on rising request when off load point
    assign rwc_accept    = ((s_rwc && sel_onl_dly) || unload_cmd_rewind) && !rwc_d_r && !s_lp;
    assign stopped_at_lp = s_lp && !s_moving;

    // hold keeps set; clear on stop at load point or broken
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rewind_ff_r <= 1'b0;
        end else if (s_bkn) begin
            rewind_ff_r <= 1'b0;
        end else if (rwc_accept || s_hold) begin
            rewind_ff_r <= 1'b1;
        end else if (stopped_at_lp) begin
            rewind_ff_r <= 1'b0;
        end
    end

    // single 5 us pulse per acceptance
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rw_pulse_cnt_r <= '0;
        end else if (rwc_accept) begin
            rw_pulse_cnt_r <= ticl_pkg::CNT_W'(ticl_pkg::REWIND_PULSE_CYC);
        end else if (rw_pulse_cnt_r != '0) begin
            rw_pulse_cnt_r <= rw_pulse_cnt_r - ticl_pkg::CNT_W'(1);
        end
    end

    // ==========================================================
    // Unload
    // ==========================================================
    logic unload_ff_r;
    logic unload_set;

    // strap selects gated or plain unload
    assign unload_set = s_unload_cmd && (s_strap || sel_onl_dly);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            unload_ff_r <= 1'b0;
        end else if (s_bkn) begin
            unload_ff_r <= 1'b0;
        end else if (unload_set) begin
            unload_ff_r <= 1'b1;
        end
    end

    // ==========================================================
    // Status outputs
    // ==========================================================
    // ready; unload out; off line with unload
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rewinding_status <= 1'b0;
            rewind_pulse     <= 1'b0;
            ready            <= 1'b0;
            unload_out       <= 1'b0;
            go_offline_cmd   <= 1'b0;
        end else begin
            rewinding_status <= rewind_ff_r;
            rewind_pulse     <= rw_pulse_cnt_r != '0;
            ready            <= !rewind_ff_r && s_sel && s_onl && !s_busy;
            unload_out       <= unload_ff_r && !rewind_ff_r;
            go_offline_cmd   <= unload_set;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_busy_block; (s_busy || !s_sel) |=> drive == 3'h0; endproperty
    a_busy_block: assert property (p_busy_block) else $error("motion while blocked");
    property p_lp_rev; s_lp |=> !drive.reverse_out; endproperty
    a_lp_rev: assert property (p_lp_rev) else $error("reverse at load point");
    property p_dir_hold; s_moving |=> $stable(dir_fwd_r); endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed while moving");
    property p_eot_fast; (s_eot && dir_fwd_r) |=> !drive.run_fast; endproperty
    a_eot_fast: assert property (p_eot_fast) else $error("run fast at end of tape");
    property p_fast_needs_normal; drive.run_fast |-> drive.run_normal; endproperty
    a_fast_needs_normal: assert property (p_fast_needs_normal) else $error("fast without normal");
    property p_ws_stable;
        (!sample_edge && !s_wars && !$past(sample_edge) && !$past(s_wars)) |=> $stable(sws_r);
    endproperty
    a_ws_stable: assert property (p_ws_stable) else $error("write status moved off sample");
    property p_ebd; ovw_ff_r |=> erase_bar_disable; endproperty
    a_ebd: assert property (p_ebd) else $error("erase bar not disabled");
    property p_wars_clr; (s_wars && !(sample_edge && s_ovw)) |=> !ovw_ff_r; endproperty
    a_wars_clr: assert property (p_wars_clr) else $error("overwrite not cleared");
    property p_pulse; rwc_accept |=> ##1 rewind_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("no rewind pulse");
    property p_bkn; s_bkn |=> !rewind_ff_r && !unload_ff_r; endproperty
    a_bkn: assert property (p_bkn) else $error("broken tape did not clear");
    property p_ready; rewind_ff_r |=> !ready; endproperty
    a_ready: assert property (p_ready) else $error("ready while rewinding");

endmodule : ticl_core

// file: dv/ticl_host_model.sv
`timescale 1ns/100ps

// ==========================================================
// Host controller model
// ==========================================================
module ticl_host_model (
    input  wire logic                   clock,
    input  wire logic                   reset,
    input  wire logic                   go,
    input  wire ticl_pkg::ticl_motion_s cmd_mv,
    input  wire ticl_pkg::ticl_wreq_s   cmd_wr,
    output ticl_pkg::ticl_motion_s      motion_req,
    output ticl_pkg::ticl_wreq_s        write_req
);
    // Motion and write levels launch on one edge and stand while go
    // holds, so they are settled long before the sampling strobe
    // simultaneous request levels
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            motion_req <= '0;
            write_req  <= '0;
        end else if (go) begin
            motion_req <= cmd_mv;
            write_req  <= cmd_wr;
        end else begin
            motion_req <= '0;
            write_req  <= '0;
        end
    end
endmodule : ticl_host_model

// file: dv/ticl_bench.sv
`timescale 1ns/100ps

// ==========================================================
// Bench for the tape interface command logic
// ==========================================================
module ticl_bench;
    logic                   clock = 1'b0;
    logic                   reset = 1'b1;
    logic                   go    = 1'b0;
    ticl_pkg::ticl_motion_s cmd_mv = '0;
    ticl_pkg::ticl_wreq_s   cmd_wr = '0;
    ticl_pkg::ticl_motion_s motion_req;
    ticl_pkg::ticl_wreq_s   write_req;
    ticl_pkg::ticl_drive_s  drive;
    logic war = 1'b0, moving = 1'b0, load_pt = 1'b0, tape_end = 1'b0, busy = 1'b0, sel = 1'b1, on_svc = 1'b1;
    logic rew_req = 1'b0, hold = 1'b0, broken = 1'b0, unl_req = 1'b0, strap = 1'b0;
    logic wr_sel, ebd, rw_stat, rw_pulse, rdy, unl_out, offl;
    int   error_cnt = 0;
    int   tests_run = 0;
    logic [31:0] seed = 32'h7379;

    // Half period of the 40 MHz clock
    always #12.5 clock = ~clock;

    ticl_host_model i_ticl_host_model (.clock(clock), .reset(reset), .go(go), .cmd_mv(cmd_mv),
        .cmd_wr(cmd_wr), .motion_req(motion_req), .write_req(write_req));

    ticl_core i_ticl_core (.clock(clock), .reset(reset), .motion_req(motion_req), .write_req(write_req),
        .write_after_read_strobe(war), .tape_moving(moving), .at_load_point(load_pt),
        .end_of_tape(tape_end), .busy_in(busy), .unit_selected(sel), .in_service(on_svc),
        .rewind_cmd(rew_req), .rewinding_hold(hold), .broken_tape(broken), .unload_cmd(unl_req),
        .unload_gating_strap(strap), .drive(drive), .write_select(wr_sel), .erase_bar_disable(ebd),
        .rewinding_status(rw_stat), .rewind_pulse(rw_pulse), .ready(rdy), .unload_out(unl_out),
        .go_offline_cmd(offl));

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // End of tape only trims the fast bit, never normal running
    function automatic logic [2:0] exp_drive(input logic f, input logic fa, input logic te);
        return {1'b1, fa & ~te, ~f};
    endfunction : exp_drive

    function automatic logic pick(input int s);
        case (s)
            0: return drive.run_normal;
            1: return wr_sel;
            2: return rw_stat;
            3: return rw_pulse;
            4: return unl_out;
            default: return rdy;
        endcase
    endfunction : pick

    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    // Inputs always move 2 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : cyc

    // Bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_for(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (pick(s) !== v) begin
            if (n == lim) begin
                error_cnt++;
                print_verdict();
            end
            cyc(1);
            n++;
        end
    endtask : wait_for

    task automatic issue(input logic [2:0] m, input logic [1:0] w);
        cmd_mv = m;
        cmd_wr = w;
        go     = 1'b1;
    endtask : issue

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        int   n;
        logic f, fa, te;
        repeat (20) @(posedge clock);
        #2;
        reset = 1'b0;
        cyc(200);
        // Random modes, tape stopped so every direction is legal
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            f = seed[0];
            fa = seed[1];
            te = seed[2] & f;
            go = 1'b0;
            tape_end = te;
            cyc(10);
            issue({f, ~f, fa}, 2'b00);
            cyc(60);
            chk(drive, exp_drive(f, fa, te));
        end
        tape_end = 1'b0;
        go = 1'b0;
        load_pt = 1'b1;
        cyc(10);
        issue(3'b010, 2'b00);
        cyc(60);
        chk(3'(drive.reverse_out), 3'h0);
        issue(3'b100, 2'b00);
        cyc(60);
        busy = 1'b1;
        cyc(8);
        chk(drive, 3'h0);
        chk(3'(rdy), 3'h0);
        busy = 1'b0;
        load_pt = 1'b0;
        cyc(8);
        sel = 1'b0;
        cyc(8);
        chk(drive, 3'h0);
        sel = 1'b1;
        wait_for(0, 1'b1, 300, n);
        // Direction interlock while the capstan still turns
        moving = 1'b1;
        issue(3'b101, 2'b00);
        cyc(8);
        chk(drive, 3'h6);
        issue(3'b010, 2'b00);
        cyc(60);
        chk(drive, 3'h0);
        moving = 1'b0;
        wait_for(0, 1'b1, 60, n);
        cyc(2);
        chk(drive, 3'h5);
        // Write sampling at the start of each run
        go = 1'b0;
        cyc(10);
        issue(3'b100, 2'b10);
        wait_for(1, 1'b1, 1000, n);
        chk(3'(n >= 600 && n <= 800), 3'h1);
        go = 1'b0;
        cyc(60);
        chk(3'(wr_sel), 3'h1);
        issue(3'b100, 2'b00);
        wait_for(1, 1'b0, 1000, n);
        chk(3'(n >= 600), 3'h1);
        go = 1'b0;
        cyc(10);
        issue(3'b100, 2'b11);
        wait_for(1, 1'b1, 1000, n);
        chk(3'(ebd), 3'h1);
        cyc(30);
        chk(3'(wr_sel), 3'h1);
        war = 1'b1;
        cyc(4);
        war = 1'b0;
        cyc(8);
        chk(3'(wr_sel), 3'h0);
        go = 1'b0;
        // Rewind right after going back on line waits for the delayed qualifier
        on_svc = 1'b0;
        cyc(10);
        chk(3'(rdy), 3'h0);
        on_svc = 1'b1;
        rew_req = 1'b1;
        wait_for(3, 1'b1, 300, n);
        chk(3'(n >= 160 && n <= 250), 3'h1);
        wait_for(3, 1'b0, 400, n);
        chk(3'(n >= 180 && n <= 220), 3'h1);
        chk(3'(rw_stat), 3'h1);
        chk(3'(rdy), 3'h0);
        rew_req = 1'b0;
        hold = 1'b1;
        cyc(300);
        chk(3'(rw_stat), 3'h1);
        chk(3'(rw_pulse), 3'h0);
        broken = 1'b1;
        cyc(8);
        chk(3'(rw_stat), 3'h0);
        hold = 1'b0;
        broken = 1'b0;
        wait_for(5, 1'b1, 20, n);
        rew_req = 1'b1;
        wait_for(2, 1'b1, 300, n);
        rew_req = 1'b0;
        moving = 1'b1;
        load_pt = 1'b1;
        cyc(20);
        chk(3'(rw_stat), 3'h1);
        moving = 1'b0;
        cyc(8);
        chk(3'(rw_stat), 3'h0);
        rew_req = 1'b1;
        cyc(300);
        chk(3'(rw_stat), 3'h0);
        rew_req = 1'b0;
        // Unload at and away from load point
        unl_req = 1'b1;
        wait_for(4, 1'b1, 300, n);
        chk(3'(offl), 3'h1);
        unl_req = 1'b0;
        broken = 1'b1;
        cyc(8);
        chk(3'(unl_out), 3'h0);
        broken = 1'b0;
        load_pt = 1'b0;
        unl_req = 1'b1;
        wait_for(2, 1'b1, 300, n);
        chk(3'(unl_out), 3'h0);
        unl_req = 1'b0;
        broken = 1'b1;
        cyc(8);
        chk(3'(rw_stat), 3'h0);
        broken = 1'b0;
        load_pt = 1'b1;
        sel = 1'b0;
        unl_req = 1'b1;
        cyc(300);
        chk(3'(unl_out), 3'h0);
        strap = 1'b1;
        cyc(300);
        chk(3'(unl_out), 3'h1);
        print_verdict();
    end
endmodule : ticl_bench
